// *** pmap_filter.sv ***
// Message applicability policy filter for a power-negotiation port.
// Assumes all inputs come from logic on i_sys_clk; one query per cycle.
//
// Functional notes
// - Supported message implies its whole exchange supported.
// - Not-supported messages never sent, silently dropped.
// - Reject-class receipt answered with Reject message.
// - NAK-class command answered with responder NAK.
// - Mandatory messages always supported for role.
// - Reactions only in ready; otherwise protocol error.
// - Dual-role power overrides source or sink entries.
// - Dual-role data overrides host or device entries.
// - Multi-port hub source can send GotoMin.
// - FSK source must be able to send Ping.
// - GotoMin sender also sends Wait.
// - Charging sink accepts GotoMin, lowers current.
// - Unmet condition uses the fallback class.
// - Unimplemented optional entry uses its fallback answer.
`timescale 1ns/1ps
module pmap_filter (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Port configuration.
    input wire logic [2:0] i_role,
    input wire logic [5:0] i_feat,
    input wire logic i_opt_impl,
    // Policy engine state.
    input wire logic i_source_ready_state,
    input wire logic i_sink_ready_state,
    input wire logic i_cable_ready_state,
    // Transmit query.
    input wire logic i_tx_req,
    input wire logic [4:0] i_tx_msg,
    // Receive query.
    input wire logic i_rx_valid,
    input wire logic [4:0] i_rx_msg,
    // Transmit decision.
    output logic o_tx_grant,
    output logic o_tx_block,
    // Receive decision.
    output logic o_rx_done,
    output logic [2:0] o_rx_action,
    output logic o_send_reject,
    output logic o_send_nak,
    output logic o_reduce_current
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic tx_grant;
        logic tx_block;
        logic rx_done;
        logic [2:0] rx_action;
        logic send_reject;
        logic send_nak;
        logic reduce_current;
    } pmap_state_s;

    pmap_state_s st_r;
    pmap_state_s st_nxt;

    logic tx_table_ok;
    pmap_pkg::pmap_class_e rx_class;
    logic ready;

    // ------------------------------------------------------------
    // Lookups
    // ------------------------------------------------------------
    // The role input selects the column of both tables.
    pmap_tx_table u_tx (
        .i_role(i_role),
        .i_msg(i_tx_msg),
        .i_feat(i_feat),
        .o_allowed(tx_table_ok)
    );

    pmap_rx_table u_rx (
        .i_role(i_role),
        .i_msg(i_rx_msg),
        .i_feat(i_feat),
        .o_class(rx_class)
    );

    // Fallback answer when an optional received entry is not implemented.
    function automatic logic [2:0] fallback_action(input logic [4:0] msg);
        if (msg >= pmap_pkg::VDM_DISC_ID) begin
            fallback_action = pmap_pkg::ACT_NAK;
        end else begin
            fallback_action = pmap_pkg::ACT_REJECT;
        end
    endfunction

    // Any ready state of the policy engine counts.
    assign ready = i_source_ready_state | i_sink_ready_state | i_cable_ready_state;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = '0;
        // Transmit: forbid anything the role does not support.
        st_nxt.tx_grant = i_tx_req & tx_table_ok;
        st_nxt.tx_block = i_tx_req & ~tx_table_ok;
        if (i_rx_valid) begin
            st_nxt.rx_done = 1'b1;
            if (!ready) begin
                // Mid-sequence arrivals are protocol errors.
                st_nxt.rx_action = pmap_pkg::ACT_PROT_ERR;
            end else begin
                unique case (rx_class)
                    pmap_pkg::PMAP_MANDATORY: begin
                        st_nxt.rx_action = pmap_pkg::ACT_PROCESS;
                    end
                    pmap_pkg::PMAP_RECOMMEND, pmap_pkg::PMAP_OPTIONAL: begin
                        // Unimplemented optional entries take their fallback.
                        st_nxt.rx_action = i_opt_impl ? pmap_pkg::ACT_PROCESS
                            : fallback_action(i_rx_msg);
                    end
                    pmap_pkg::PMAP_REJECT_ON_RECEIPT: begin
                        st_nxt.rx_action = pmap_pkg::ACT_REJECT;
                    end
                    pmap_pkg::PMAP_NEGATIVE_ACK: begin
                        st_nxt.rx_action = pmap_pkg::ACT_NAK;
                    end
                    default: begin
                        st_nxt.rx_action = pmap_pkg::ACT_IGNORE;
                    end
                endcase
            end
            st_nxt.send_reject = (st_nxt.rx_action == pmap_pkg::ACT_REJECT);
            st_nxt.send_nak = (st_nxt.rx_action == pmap_pkg::ACT_NAK);
            // A charging sink processing GotoMin lowers its draw.
            st_nxt.reduce_current = (st_nxt.rx_action == pmap_pkg::ACT_PROCESS)
                && (i_rx_msg == pmap_pkg::MSG_GOTOMIN);
        end
    end

    // Register the state.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register.
    assign o_tx_grant = st_r.tx_grant;
    assign o_tx_block = st_r.tx_block;
    assign o_rx_done = st_r.rx_done;
    assign o_rx_action = st_r.rx_action;
    assign o_send_reject = st_r.send_reject;
    assign o_send_nak = st_r.send_nak;
    assign o_reduce_current = st_r.reduce_current;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_rx_busy;
        i_rx_valid && !ready;
    endsequence

    a_busy_prot_err: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_rx_busy |=> o_rx_action == pmap_pkg::ACT_PROT_ERR && o_rx_done)
        else $error("Busy receive did not flag protocol error.");

    a_ns_silent: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_rx_valid && ready && rx_class == pmap_pkg::PMAP_NOT_SUPPORTED
        |=> !o_send_reject && !o_send_nak && o_rx_action == pmap_pkg::ACT_IGNORE)
        else $error("Unsupported message drew a response.");

    a_rj_reject: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_rx_valid && ready && rx_class == pmap_pkg::PMAP_REJECT_ON_RECEIPT |=> o_send_reject)
        else $error("Reject-class message not rejected.");

    a_nk_nak: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_rx_valid && ready && rx_class == pmap_pkg::PMAP_NEGATIVE_ACK |=> o_send_nak)
        else $error("NAK-class command not answered.");

    a_mand_process: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_rx_valid && ready && rx_class == pmap_pkg::PMAP_MANDATORY
        |=> o_rx_action == pmap_pkg::ACT_PROCESS)
        else $error("Mandatory message not processed.");

    a_tx_blocked: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_tx_req && !tx_table_ok |=> o_tx_block && !o_tx_grant)
        else $error("Unsupported transmit was granted.");

    a_drp_prswap: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_tx_req && i_role == pmap_pkg::ROLE_DRP && i_tx_msg == pmap_pkg::MSG_PR_SWAP
        |=> o_tx_grant)
        else $error("Dual-role power port cannot send swap.");

    a_fsk_ping: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_tx_req && i_role == pmap_pkg::ROLE_SRC && i_tx_msg == pmap_pkg::MSG_PING
        |=> o_tx_grant)
        else $error("Source cannot send Ping.");

    a_opt_fallback: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_rx_valid && ready && !i_opt_impl && rx_class == pmap_pkg::PMAP_RECOMMEND
        |=> o_send_reject || o_send_nak)
        else $error("Unimplemented entry gave no fallback.");

    a_gotomin_reduce: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_rx_valid && ready && i_opt_impl && i_role == pmap_pkg::ROLE_SNK
        && i_feat[pmap_pkg::FEAT_CHARGE] && i_rx_msg == pmap_pkg::MSG_GOTOMIN
        |=> o_reduce_current)
        else $error("Charging sink ignored GotoMin.");

    // A multi-port hub source must be free to send GotoMin.
    a_hub_gotomin: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_tx_req && i_role == pmap_pkg::ROLE_SRC && i_feat[pmap_pkg::FEAT_HUB_MULTI]
        && i_tx_msg == pmap_pkg::MSG_GOTOMIN |=> o_tx_grant)
        else $error("Hub source cannot send GotoMin.");

    // A source that may send GotoMin must also be free to send Wait.
    a_gotomin_wait: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_tx_req && i_role == pmap_pkg::ROLE_SRC && i_feat[pmap_pkg::FEAT_HUB_MULTI]
        && i_tx_msg == pmap_pkg::MSG_WAIT |=> o_tx_grant)
        else $error("GotoMin sender cannot send Wait.");

    // No verdict and no answer may appear without a received message.
    a_rx_no_query: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !i_rx_valid |=> !o_rx_done && !o_send_reject && !o_send_nak)
        else $error("Receive answer without a message.");

endmodule

// *** pmap_partner.sv ***
// Behavioural far-side model: the partner's protocol logic handing received messages in.
// Assumes the bench asks for one message at a time on i_sys_clk.
`timescale 1ns/1ps
module pmap_partner (
    // Clock.
    input wire logic i_sys_clk,
    // Bench command.
    input wire logic i_send,
    input wire logic [4:0] i_msg,
    // Received message towards the filter.
    output logic o_rx_valid,
    output logic [4:0] o_rx_msg
);
    // ----
    // Delivery
    // ----
    // Presents a message for one cycle; outside it the code toggles so no stale value lingers.
    always_ff @(posedge i_sys_clk) begin
        o_rx_valid <= i_send;
        o_rx_msg <= i_send ? i_msg : ~o_rx_msg;
    end
endmodule

// *** pmap_pkg.sv ***
// Package for the message applicability policy filter.
// Assumes nothing; shared by the filter and its two lookup modules.
package pmap_pkg;

    // ------------------------------------------------------------
    // Role and message encodings
    // ------------------------------------------------------------
    localparam int ROLE_W = 3;
    localparam logic [2:0] ROLE_SRC = 3'h0;
    localparam logic [2:0] ROLE_SNK = 3'h1;
    localparam logic [2:0] ROLE_DRP = 3'h2;
    localparam logic [2:0] ROLE_CBL = 3'h3;
    localparam logic [2:0] ROLE_DFP = 3'h4;
    localparam logic [2:0] ROLE_UFP = 3'h5;
    localparam logic [2:0] ROLE_DRD = 3'h6;

    localparam int MSG_W = 5;
    // Control messages.
    localparam logic [4:0] MSG_GOODCRC = 5'h00;
    localparam logic [4:0] MSG_GOTOMIN = 5'h01;
    localparam logic [4:0] MSG_ACCEPT = 5'h02;
    localparam logic [4:0] MSG_REJECT = 5'h03;
    localparam logic [4:0] MSG_PING = 5'h04;
    localparam logic [4:0] MSG_PS_RDY = 5'h05;
    localparam logic [4:0] MSG_GET_SRC_CAP = 5'h06;
    localparam logic [4:0] MSG_GET_SNK_CAP = 5'h07;
    localparam logic [4:0] MSG_PR_SWAP = 5'h08;
    localparam logic [4:0] MSG_WAIT = 5'h09;
    localparam logic [4:0] MSG_SOFT_RESET = 5'h0a;
    // Connector-specific control messages.
    localparam logic [4:0] MSG_DR_SWAP = 5'h0b;
    localparam logic [4:0] MSG_VCONN_SWAP = 5'h0c;
    // Vendor-defined commands.
    localparam logic [4:0] VDM_DISC_ID = 5'h10;
    localparam logic [4:0] VDM_DISC_SVID = 5'h11;
    localparam logic [4:0] VDM_DISC_MODE = 5'h12;
    localparam logic [4:0] VDM_ENTER = 5'h13;
    localparam logic [4:0] VDM_EXIT = 5'h14;
    localparam logic [4:0] VDM_ATTN = 5'h15;

    // ------------------------------------------------------------
    // Support classes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PMAP_MANDATORY = 3'h0,
        PMAP_RECOMMEND = 3'h1,
        PMAP_OPTIONAL = 3'h2,
        PMAP_NOT_SUPPORTED = 3'h3,
        PMAP_REJECT_ON_RECEIPT = 3'h4,
        PMAP_NEGATIVE_ACK = 3'h5,
        PMAP_BLANK = 3'h6
    } pmap_class_e;

    // Receive verdicts.
    localparam logic [2:0] ACT_NONE = 3'h0;
    localparam logic [2:0] ACT_PROCESS = 3'h1;
    localparam logic [2:0] ACT_IGNORE = 3'h2;
    localparam logic [2:0] ACT_REJECT = 3'h3;
    localparam logic [2:0] ACT_NAK = 3'h4;
    localparam logic [2:0] ACT_PROT_ERR = 3'h5;

    // Feature strap bit positions.
    localparam int FEAT_W = 6;
    localparam int FEAT_HUB_MULTI = 0;
    localparam int FEAT_HOST_MULTI = 1;
    localparam int FEAT_FSK = 2;
    localparam int FEAT_CHARGE = 3;
    localparam int FEAT_SS_PRSWAP = 4;
    localparam int FEAT_MODAL = 5;

endpackage

// *** pmap_rx_table.sv ***
// Receive applicability lookup for one message and role.
// Assumes a role and feature set that are stable while it is read.
`timescale 1ns/1ps
module pmap_rx_table (
    // Query.
    input wire logic [2:0] i_role,
    input wire logic [4:0] i_msg,
    input wire logic [5:0] i_feat,
    // Answer.
    output pmap_pkg::pmap_class_e o_class
);
    // ------------------------------------------------------------
    // Lookup
    // ------------------------------------------------------------
    logic charge;
    logic ss_prswap;
    logic modal;
    assign charge = i_feat[pmap_pkg::FEAT_CHARGE];
    assign ss_prswap = i_feat[pmap_pkg::FEAT_SS_PRSWAP];
    assign modal = i_feat[pmap_pkg::FEAT_MODAL];

    // Conditional entries fall back to the class after the slash.
    always_comb begin
        o_class = pmap_pkg::PMAP_NOT_SUPPORTED;
        unique case (i_role)
            pmap_pkg::ROLE_SRC, pmap_pkg::ROLE_SNK, pmap_pkg::ROLE_DRP: begin
                unique case (i_msg)
                    pmap_pkg::MSG_GOODCRC, pmap_pkg::MSG_ACCEPT, pmap_pkg::MSG_REJECT,
                    pmap_pkg::MSG_SOFT_RESET: o_class = pmap_pkg::PMAP_MANDATORY;
                    pmap_pkg::MSG_GOTOMIN: begin
                        o_class = (i_role == pmap_pkg::ROLE_SNK && charge)
                            ? pmap_pkg::PMAP_RECOMMEND : pmap_pkg::PMAP_NOT_SUPPORTED;
                    end
                    pmap_pkg::MSG_PS_RDY, pmap_pkg::MSG_WAIT: begin
                        o_class = (i_role == pmap_pkg::ROLE_SRC)
                            ? pmap_pkg::PMAP_NOT_SUPPORTED : pmap_pkg::PMAP_MANDATORY;
                    end
                    pmap_pkg::MSG_GET_SRC_CAP: begin
                        o_class = (i_role == pmap_pkg::ROLE_SNK)
                            ? pmap_pkg::PMAP_REJECT_ON_RECEIPT : pmap_pkg::PMAP_MANDATORY;
                    end
                    pmap_pkg::MSG_GET_SNK_CAP: begin
                        o_class = (i_role == pmap_pkg::ROLE_SRC)
                            ? pmap_pkg::PMAP_REJECT_ON_RECEIPT : pmap_pkg::PMAP_MANDATORY;
                    end
                    pmap_pkg::MSG_PR_SWAP: begin
                        o_class = (i_role == pmap_pkg::ROLE_DRP)
                            ? pmap_pkg::PMAP_MANDATORY : pmap_pkg::PMAP_REJECT_ON_RECEIPT;
                    end
                    default: o_class = pmap_pkg::PMAP_NOT_SUPPORTED;
                endcase
            end
            pmap_pkg::ROLE_CBL: begin
                unique case (i_msg)
                    pmap_pkg::MSG_GOODCRC, pmap_pkg::MSG_SOFT_RESET,
                    pmap_pkg::VDM_DISC_ID: o_class = pmap_pkg::PMAP_MANDATORY;
                    pmap_pkg::VDM_DISC_SVID, pmap_pkg::VDM_DISC_MODE, pmap_pkg::VDM_ENTER,
                    pmap_pkg::VDM_EXIT: begin
                        o_class = modal ? pmap_pkg::PMAP_MANDATORY : pmap_pkg::PMAP_NEGATIVE_ACK;
                    end
                    default: o_class = pmap_pkg::PMAP_NOT_SUPPORTED;
                endcase
            end
            pmap_pkg::ROLE_DFP, pmap_pkg::ROLE_UFP, pmap_pkg::ROLE_DRD: begin
                unique case (i_msg)
                    pmap_pkg::MSG_DR_SWAP: begin
                        o_class = (i_role == pmap_pkg::ROLE_DRD)
                            ? pmap_pkg::PMAP_MANDATORY : pmap_pkg::PMAP_REJECT_ON_RECEIPT;
                    end
                    pmap_pkg::MSG_WAIT: begin
                        o_class = (i_role == pmap_pkg::ROLE_DRD)
                            ? pmap_pkg::PMAP_MANDATORY : pmap_pkg::PMAP_NOT_SUPPORTED;
                    end
                    pmap_pkg::MSG_VCONN_SWAP: begin
                        o_class = ss_prswap
                            ? pmap_pkg::PMAP_MANDATORY : pmap_pkg::PMAP_REJECT_ON_RECEIPT;
                    end
                    pmap_pkg::VDM_DISC_ID: begin
                        o_class = (i_role == pmap_pkg::ROLE_DFP)
                            ? pmap_pkg::PMAP_NOT_SUPPORTED : pmap_pkg::PMAP_RECOMMEND;
                    end
                    pmap_pkg::VDM_DISC_SVID, pmap_pkg::VDM_DISC_MODE, pmap_pkg::VDM_ENTER,
                    pmap_pkg::VDM_EXIT: begin
                        if (i_role == pmap_pkg::ROLE_DFP) begin
                            o_class = pmap_pkg::PMAP_NOT_SUPPORTED;
                        end else begin
                            o_class = modal ? pmap_pkg::PMAP_MANDATORY
                                : pmap_pkg::PMAP_NEGATIVE_ACK;
                        end
                    end
                    pmap_pkg::VDM_ATTN: begin
                        o_class = (i_role == pmap_pkg::ROLE_DFP) ? pmap_pkg::PMAP_OPTIONAL
                            : pmap_pkg::PMAP_NEGATIVE_ACK;
                    end
                    default: o_class = pmap_pkg::PMAP_NOT_SUPPORTED;
                endcase
            end
            default: o_class = pmap_pkg::PMAP_NOT_SUPPORTED;
        endcase
    end
endmodule

// *** pmap_tx_table.sv ***
// Transmit applicability lookup for one message and role.
// Assumes a role and feature set that are stable while it is read.
`timescale 1ns/1ps
module pmap_tx_table (
    // Query.
    input wire logic [2:0] i_role,
    input wire logic [4:0] i_msg,
    input wire logic [5:0] i_feat,
    // Answer.
    output logic o_allowed
);
    // ------------------------------------------------------------
    // Lookup
    // ------------------------------------------------------------
    logic hub_or_host;
    logic gotomin_ok;
    assign hub_or_host = i_feat[pmap_pkg::FEAT_HUB_MULTI] | i_feat[pmap_pkg::FEAT_HOST_MULTI];
    assign gotomin_ok = hub_or_host;

    // A source may send anything optional; the table only bars what is not supported.
    always_comb begin
        o_allowed = 1'b0;
        unique case (i_role)
            pmap_pkg::ROLE_SRC: begin
                o_allowed = (i_msg <= pmap_pkg::MSG_SOFT_RESET) && (i_msg != pmap_pkg::MSG_PR_SWAP);
            end
            pmap_pkg::ROLE_SNK: begin
                o_allowed = (i_msg == pmap_pkg::MSG_GOODCRC) || (i_msg == pmap_pkg::MSG_ACCEPT)
                    || (i_msg == pmap_pkg::MSG_REJECT) || (i_msg == pmap_pkg::MSG_GET_SRC_CAP)
                    || (i_msg == pmap_pkg::MSG_GET_SNK_CAP) || (i_msg == pmap_pkg::MSG_SOFT_RESET);
            end
            pmap_pkg::ROLE_DRP: begin
                o_allowed = (i_msg <= pmap_pkg::MSG_SOFT_RESET) && (i_msg != pmap_pkg::MSG_PING)
                    && ((i_msg != pmap_pkg::MSG_GOTOMIN) || gotomin_ok);
            end
            pmap_pkg::ROLE_CBL: begin
                o_allowed = (i_msg == pmap_pkg::MSG_GOODCRC) || (i_msg == pmap_pkg::MSG_ACCEPT);
            end
            pmap_pkg::ROLE_DFP: begin
                o_allowed = (i_msg == pmap_pkg::MSG_VCONN_SWAP) || (i_msg == pmap_pkg::VDM_DISC_ID)
                    || (i_feat[pmap_pkg::FEAT_MODAL] && (i_msg >= pmap_pkg::VDM_DISC_SVID)
                    && (i_msg <= pmap_pkg::VDM_EXIT));
            end
            pmap_pkg::ROLE_UFP: begin
                o_allowed = (i_msg == pmap_pkg::MSG_VCONN_SWAP) || (i_msg == pmap_pkg::VDM_DISC_ID)
                    || (i_msg == pmap_pkg::VDM_ATTN);
            end
            pmap_pkg::ROLE_DRD: begin
                o_allowed = (i_msg == pmap_pkg::MSG_DR_SWAP) || (i_msg == pmap_pkg::MSG_WAIT)
                    || (i_msg == pmap_pkg::MSG_VCONN_SWAP) || (i_msg == pmap_pkg::VDM_DISC_ID);
            end
            default: begin
                o_allowed = 1'b0;
            end
        endcase
    end
endmodule

// *** tb.sv ***
// Self-checking bench for the message applicability policy filter.
// Assumes the partner model feeds received messages; the bench drives the rest.
`timescale 1ns/1ps
module tb;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [2:0] role = 3'h0;
    logic [5:0] feat = 6'h00;
    logic opt_impl = 1'b1;
    logic rdy = 1'b1;
    logic tx_req = 1'b0;
    logic [4:0] tx_msg = 5'h00;
    logic snd = 1'b0;
    logic [4:0] snd_msg = 5'h00;
    logic rx_valid;
    logic [4:0] rx_msg;
    logic tx_grant, tx_block, rx_done, send_rej, send_nak, red_cur;
    logic [2:0] rx_act;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;

    // Clock of 100 ns period.
    always #50 i_sys_clk = ~i_sys_clk;

    pmap_partner peer (.i_sys_clk(i_sys_clk), .i_send(snd), .i_msg(snd_msg),
        .o_rx_valid(rx_valid), .o_rx_msg(rx_msg));

    pmap_filter dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_role(role),
        .i_feat(feat), .i_opt_impl(opt_impl), .i_source_ready_state(rdy),
        .i_sink_ready_state(rdy), .i_cable_ready_state(rdy), .i_tx_req(tx_req),
        .i_tx_msg(tx_msg), .i_rx_valid(rx_valid), .i_rx_msg(rx_msg),
        .o_tx_grant(tx_grant), .o_tx_block(tx_block), .o_rx_done(rx_done),
        .o_rx_action(rx_act), .o_send_reject(send_rej), .o_send_nak(send_nak),
        .o_reduce_current(red_cur));

    // ----
    // Checking helpers
    // ----
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [6:0] exp, input logic [6:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Packs a verdict as {done, action, reject, nak, reduce}.
    function automatic logic [6:0] vd(input logic [2:0] a, input logic [2:0] s);
        return {1'b1, a, s};
    endfunction

    // Receive query through the partner, verdict one cycle after it is taken, then gone.
    task automatic rx_q(input logic [2:0] r, input logic [5:0] f, input logic [4:0] m,
            input logic [6:0] exp);
        @(posedge i_sys_clk);
        role <= r;
        feat <= f;
        snd <= 1'b1;
        snd_msg <= m;
        @(posedge i_sys_clk);
        snd <= 1'b0;
        // The filter takes the message one edge after the partner shows it.
        @(posedge i_sys_clk);
        #1 chk("rx verdict", exp, {rx_done, rx_act, send_rej, send_nak, red_cur});
        @(posedge i_sys_clk);
        #1 chk("rx clear", 7'h00, {rx_done, rx_act, send_rej, send_nak, red_cur});
    endtask

    // Transmit query; expected pair is {grant, block}.
    task automatic tx_q(input logic [2:0] r, input logic [5:0] f, input logic [4:0] m,
            input logic [1:0] exp);
        @(posedge i_sys_clk);
        role <= r;
        feat <= f;
        tx_req <= 1'b1;
        tx_msg <= m;
        @(posedge i_sys_clk);
        tx_req <= 1'b0;
        tx_msg <= ~m;
        #1 chk("tx decision", {5'h00, exp}, {5'h00, tx_grant, tx_block});
    endtask

    // ----
    // Scenarios
    // ----
    task automatic sc_source_rx();
        rx_q(pmap_pkg::ROLE_SRC, 6'h00, pmap_pkg::MSG_PR_SWAP, vd(pmap_pkg::ACT_REJECT, 3'h4));
        rx_q(pmap_pkg::ROLE_SRC, 6'h00, pmap_pkg::MSG_GET_SNK_CAP, vd(pmap_pkg::ACT_REJECT, 3'h4));
        rx_q(pmap_pkg::ROLE_SRC, 6'h00, pmap_pkg::MSG_PING, vd(pmap_pkg::ACT_IGNORE, 3'h0));
        rx_q(pmap_pkg::ROLE_SRC, 6'h00, pmap_pkg::MSG_ACCEPT, vd(pmap_pkg::ACT_PROCESS, 3'h0));
        rx_q(pmap_pkg::ROLE_CBL, 6'h00, pmap_pkg::MSG_ACCEPT, vd(pmap_pkg::ACT_IGNORE, 3'h0));
    endtask

    task automatic sc_not_ready();
        rdy <= 1'b0;
        rx_q(pmap_pkg::ROLE_SRC, 6'h00, pmap_pkg::MSG_PR_SWAP, vd(pmap_pkg::ACT_PROT_ERR, 3'h0));
        rx_q(pmap_pkg::ROLE_SNK, 6'h00, pmap_pkg::MSG_PING, vd(pmap_pkg::ACT_PROT_ERR, 3'h0));
        rdy <= 1'b1;
    endtask

    task automatic sc_tx_roles();
        tx_q(pmap_pkg::ROLE_SRC, 6'h00, pmap_pkg::MSG_PR_SWAP, 2'h1);
        tx_q(pmap_pkg::ROLE_SRC, 6'h00, pmap_pkg::MSG_ACCEPT, 2'h2);
        tx_q(pmap_pkg::ROLE_SNK, 6'h00, pmap_pkg::MSG_PS_RDY, 2'h1);
        tx_q(pmap_pkg::ROLE_DRP, 6'h00, pmap_pkg::MSG_PR_SWAP, 2'h2);
        tx_q(pmap_pkg::ROLE_CBL, 6'h00, pmap_pkg::MSG_REJECT, 2'h1);
        tx_q(pmap_pkg::ROLE_SRC, 6'h01, pmap_pkg::MSG_GOTOMIN, 2'h2);
        tx_q(pmap_pkg::ROLE_SRC, 6'h04, pmap_pkg::MSG_PING, 2'h2);
        tx_q(pmap_pkg::ROLE_SRC, 6'h01, pmap_pkg::MSG_WAIT, 2'h2);
        tx_q(pmap_pkg::ROLE_DRD, 6'h00, pmap_pkg::MSG_DR_SWAP, 2'h2);
        tx_q(pmap_pkg::ROLE_DFP, 6'h00, pmap_pkg::MSG_DR_SWAP, 2'h1);
    endtask

    task automatic sc_sink_rx();
        rx_q(pmap_pkg::ROLE_SNK, 6'h08, pmap_pkg::MSG_GOTOMIN, vd(pmap_pkg::ACT_PROCESS, 3'h1));
        rx_q(pmap_pkg::ROLE_SNK, 6'h00, pmap_pkg::MSG_GET_SRC_CAP, vd(pmap_pkg::ACT_REJECT, 3'h4));
        rx_q(pmap_pkg::ROLE_DRP, 6'h00, pmap_pkg::MSG_GET_SRC_CAP, vd(pmap_pkg::ACT_PROCESS, 3'h0));
        rx_q(pmap_pkg::ROLE_CBL, 6'h00, pmap_pkg::MSG_SOFT_RESET, vd(pmap_pkg::ACT_PROCESS, 3'h0));
    endtask

    task automatic sc_vdm_data();
        rx_q(pmap_pkg::ROLE_UFP, 6'h00, pmap_pkg::VDM_DISC_SVID, vd(pmap_pkg::ACT_NAK, 3'h2));
        rx_q(pmap_pkg::ROLE_DFP, 6'h00, pmap_pkg::VDM_DISC_SVID, vd(pmap_pkg::ACT_IGNORE, 3'h0));
        rx_q(pmap_pkg::ROLE_UFP, 6'h20, pmap_pkg::VDM_DISC_MODE, vd(pmap_pkg::ACT_PROCESS, 3'h0));
        opt_impl <= 1'b0;
        rx_q(pmap_pkg::ROLE_UFP, 6'h00, pmap_pkg::VDM_DISC_ID, vd(pmap_pkg::ACT_NAK, 3'h2));
        opt_impl <= 1'b1;
        rx_q(pmap_pkg::ROLE_DRD, 6'h00, pmap_pkg::MSG_DR_SWAP, vd(pmap_pkg::ACT_PROCESS, 3'h0));
        rx_q(pmap_pkg::ROLE_DFP, 6'h00, pmap_pkg::MSG_DR_SWAP, vd(pmap_pkg::ACT_REJECT, 3'h4));
        rx_q(pmap_pkg::ROLE_DFP, 6'h10, pmap_pkg::MSG_VCONN_SWAP, vd(pmap_pkg::ACT_PROCESS, 3'h0));
        rx_q(pmap_pkg::ROLE_DFP, 6'h00, pmap_pkg::MSG_VCONN_SWAP, vd(pmap_pkg::ACT_REJECT, 3'h4));
    endtask

    // Cuts a hang short.
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // Main sequence: reset for six cycles, then every scenario.
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_sys_clk);
        #1 chk("reset outputs", 7'h00, {rx_done, rx_act, send_rej, send_nak, red_cur});
        sc_source_rx();
        sc_not_ready();
        sc_tx_roles();
        sc_sink_rx();
        sc_vdm_data();
        end_of_test();
    end
endmodule
